// ==== pkg/rscfg_pkg.sv ====
// Package for the reference select and pump configuration register
package rscfg_pkg;
	// ****************************************************
	// Register map and field positions
	// ****************************************************
	localparam logic [7:0]  REG_OFFSET   = 8'h00;
	localparam int          REG_WIDTH    = 28;
	localparam logic [27:0] REG_RESET    = 28'h0000000;
	localparam logic [27:0] REG_WMASK    = 28'hffffeff; // Bit 8 kept zero
	localparam int          BIT_BUF_X    = 0;
	localparam int          BIT_BUF_Y    = 1;
	localparam int          BIT_PRI_PICK = 2;
	localparam int          BIT_SEC_PICK = 3;
	localparam int          BIT_AUX_PICK = 4;
	localparam int          BIT_SRC_CTL  = 5;
	localparam int          BIT_PFD_W0   = 6;
	localparam int          BIT_PUMP_DIR = 9;
	localparam int          BIT_PUMP_SRC = 10;
	localparam int          BIT_PUMP_SNK = 11;
	localparam int          BIT_PUMP_AMP = 12;

	// Buffer type codes, read as XY
	typedef enum logic [1:0]
	{
		RSCFG_BUF_CMOS = 2'h0,
		RSCFG_BUF_PECL = 2'h2,
		RSCFG_BUF_LVDS = 2'h3
	} rscfg_buf_t;

	// Reference source chosen
	typedef enum logic [2:0]
	{
		RSCFG_SRC_NONE = 3'h0,
		RSCFG_SRC_PRI  = 3'h1,
		RSCFG_SRC_SEC  = 3'h2,
		RSCFG_SRC_AUTO = 3'h3,
		RSCFG_SRC_AUX  = 3'h4
	} rscfg_src_t;

	// Decoded controls towards the analogue blocks
	typedef struct packed
	{
		logic [1:0] buf_type;
		rscfg_src_t source;
		logic       primary_buffer_on;
		logic       secondary_buffer_on;
		logic [1:0] pfd_width;
		logic       pump_negative;
		logic       pump_src_on;
		logic       pump_snk_on;
		logic       pump_amp_off;
	} rscfg_ctl_t;
endpackage

// ==== verilog/rscfg_reg.sv ====
// Reference select and charge pump configuration register
`timescale 1ns/100ps

// What this block does
// - XY 10 PECL, 11 LVDS, 00 CMOS
// - Bits 2,3 only count when control bit set
// - Register 00 selects no buffer
// - Register 10 primary, secondary buffer off
// - Register 01 secondary, primary buffer off
// - Register 11 automatic, primary then secondary
// - Aux bit 0 follows bits 2,3, or the pin when control bit clear
// - Aux bit 1 overrides with aux clock
// - Control bit 0 means pin chooses, no auto
// - Control bit 1 ignores the select pin
// - Bits 6,7 set detector pulse width
// - Bit 9 sets pump current direction
// - Bit 10 switches pump source on
// - Bit 11 switches pump sink on
// - Bit 12 switches pump amplifier off
// - Power up loads from stored configuration
module rscfg_reg
	import rscfg_pkg::*;
(
	input  wire logic        I_CLK,        // System clock, 200 MHz
	input  wire logic        I_RST,        // Synchronous reset, active high
	input  wire logic        I_WR,         // Register write strobe
	input  wire logic [7:0]  I_ADDR,       // Register address
	input  wire logic [27:0] I_WDATA,      // Write data
	output logic      [27:0] O_RDATA,      // Read data
	input  wire logic        I_LOAD,       // Power up load strobe
	input  wire logic [27:0] I_LOAD_DATA,  // Stored configuration word
	input  wire logic        I_REF_SEL,    // External select pin, high primary
	output rscfg_ctl_t       O_CTL         // Decoded controls
);
	// ****************************************************
	// Pin synchroniser
	// ****************************************************
	logic sel_meta_reg;
	logic sel_sync_reg;
	logic sel_meta_next;
	logic sel_sync_next;

	// Two stages before anyone reads the pin
	always_comb
	begin
		sel_meta_next = I_REF_SEL;
		sel_sync_next = sel_meta_reg;
	end

	always_ff @(posedge I_CLK)
	begin
		sel_meta_reg <= sel_meta_next;
		sel_sync_reg <= sel_sync_next;
	end

	// ****************************************************
	// Configuration word
	// ****************************************************
	logic [27:0] cfg_reg;
	logic [27:0] cfg_next;

	// Load wins over a write: the stored word defines power-up state
	always_comb
	begin
		cfg_next = cfg_reg;
		if (I_LOAD)
		begin
			cfg_next = I_LOAD_DATA & REG_WMASK;
		end
		else if (I_WR && I_ADDR == REG_OFFSET)
		begin
			cfg_next = I_WDATA & REG_WMASK;
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			cfg_reg <= REG_RESET;
		else
			cfg_reg <= cfg_next;
	end

	// Unmapped addresses read zero
	always_comb
	begin
		if (I_ADDR == REG_OFFSET)
			O_RDATA = cfg_reg;
		else
			O_RDATA = '0;
	end

	// ****************************************************
	// Source decode
	// ****************************************************
	function automatic rscfg_src_t pick_source(input logic [27:0] c, input logic pin);
		rscfg_src_t s;
		s = RSCFG_SRC_NONE;
		if (c[BIT_AUX_PICK])
			s = RSCFG_SRC_AUX;
		else if (!c[BIT_SRC_CTL])
			s = pin ? RSCFG_SRC_PRI : RSCFG_SRC_SEC;
		else
		begin
			case ({c[BIT_PRI_PICK], c[BIT_SEC_PICK]})
				2'h0: s = RSCFG_SRC_NONE;
				2'h2: s = RSCFG_SRC_PRI;
				2'h1: s = RSCFG_SRC_SEC;
				default: s = RSCFG_SRC_AUTO;
			endcase
		end
		return s;
	endfunction

	rscfg_ctl_t ctl_reg;
	rscfg_ctl_t ctl_next;

	// Controls are registered so the analogue side sees clean levels
	always_comb
	begin
		ctl_next.buf_type      = {cfg_reg[BIT_BUF_X], cfg_reg[BIT_BUF_Y]};
		ctl_next.source        = pick_source(cfg_reg, sel_sync_reg);
		ctl_next.primary_buffer_on    = ctl_next.source inside {RSCFG_SRC_PRI, RSCFG_SRC_AUTO};
		ctl_next.secondary_buffer_on    = ctl_next.source inside {RSCFG_SRC_SEC, RSCFG_SRC_AUTO};
		ctl_next.pfd_width     = cfg_reg[BIT_PFD_W0 +: 2];
		ctl_next.pump_negative = cfg_reg[BIT_PUMP_DIR];
		ctl_next.pump_src_on   = cfg_reg[BIT_PUMP_SRC];
		ctl_next.pump_snk_on   = cfg_reg[BIT_PUMP_SNK];
		ctl_next.pump_amp_off  = cfg_reg[BIT_PUMP_AMP];
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			ctl_reg <= '0;
		else
			ctl_reg <= ctl_next;
	end

	assign O_CTL = ctl_reg;

	// ****************************************************
	// Assertions
	// ****************************************************
	sequence reg_write_s;
		I_WR && !I_LOAD && I_ADDR == REG_OFFSET;
	endsequence

	write_lands_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		reg_write_s |=> cfg_reg == ($past(I_WDATA) & REG_WMASK))
		else $error("write not stored");
	load_lands_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_LOAD |=> cfg_reg == ($past(I_LOAD_DATA) & REG_WMASK))
		else $error("load not stored");
	aux_override_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		cfg_reg[BIT_AUX_PICK] |=> O_CTL.source == RSCFG_SRC_AUX)
		else $error("aux pick ignored");
	pin_choice_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!cfg_reg[BIT_AUX_PICK] && !cfg_reg[BIT_SRC_CTL] |=>
		O_CTL.source == ($past(sel_sync_reg) ? RSCFG_SRC_PRI : RSCFG_SRC_SEC))
		else $error("pin choice wrong");
	reg_none_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		cfg_reg[5:2] == 4'h8 |=> !O_CTL.primary_buffer_on && !O_CTL.secondary_buffer_on)
		else $error("buffer active with none");
	reg_primary_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		cfg_reg[5:2] == 4'h9 |=> O_CTL.primary_buffer_on && !O_CTL.secondary_buffer_on)
		else $error("primary pick wrong");
	reg_secondary_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		cfg_reg[5:2] == 4'ha |=> !O_CTL.primary_buffer_on && O_CTL.secondary_buffer_on)
		else $error("secondary pick wrong");
	reg_auto_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		cfg_reg[5:2] == 4'hb |=> O_CTL.source == RSCFG_SRC_AUTO)
		else $error("auto pick wrong");
	pump_bits_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		1'b1 |=> {O_CTL.pump_amp_off, O_CTL.pump_snk_on, O_CTL.pump_src_on,
		O_CTL.pump_negative} == $past(cfg_reg[12:9]))
		else $error("pump bits wrong");
	buf_type_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		1'b1 |=> O_CTL.buf_type == {$past(cfg_reg[0]), $past(cfg_reg[1])})
		else $error("buffer type wrong");

	// ****************************************************
	// Further field and mode checks
	// ****************************************************
	// Register mode with the word unchanged since the previous cycle
	sequence ctl_mode_steady_s;
		cfg_reg[BIT_SRC_CTL] && $stable(cfg_reg);
	endsequence

	// Pulse width bits pass straight through, bit 6 lowest
	pfd_width_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		1'b1 |=> O_CTL.pfd_width == $past(cfg_reg[7:6]))
		else $error("pulse width wrong");
	// Reserved bit must never be stored as one
	reserved_zero_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		1'b1 |-> !cfg_reg[8])
		else $error("reserved bit set");
	// Pin toggling must not move the source in register mode
	pin_ignored_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		ctl_mode_steady_s |=> $stable(O_CTL.source))
		else $error("pin moved source");
	// Pin mode never offers automatic selection
	no_auto_pin_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!cfg_reg[BIT_SRC_CTL] |=> O_CTL.source != RSCFG_SRC_AUTO)
		else $error("auto in pin mode");
	// Primary chosen means the secondary buffer is powered down
	pri_buffers_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_CTL.source == RSCFG_SRC_PRI |-> O_CTL.primary_buffer_on && !O_CTL.secondary_buffer_on)
		else $error("primary buffers wrong");
	// Secondary chosen means the primary buffer is powered down
	sec_buffers_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_CTL.source == RSCFG_SRC_SEC |-> !O_CTL.primary_buffer_on && O_CTL.secondary_buffer_on)
		else $error("secondary buffers wrong");
	// Aux clock in use leaves both reference buffers idle
	aux_buffers_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_CTL.source == RSCFG_SRC_AUX |-> !O_CTL.primary_buffer_on && !O_CTL.secondary_buffer_on)
		else $error("aux buffers wrong");
	// Aux bit clear in register mode never yields the aux source
	aux_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!cfg_reg[BIT_AUX_PICK] && cfg_reg[BIT_SRC_CTL] |=> O_CTL.source != RSCFG_SRC_AUX)
		else $error("aux taken when clear");
endmodule

// ==== verif/rscfg_reg_tb.sv ====
// Self-checking testbench for the reference select configuration register
`timescale 1ns/100ps
module rscfg_reg_tb
	import rscfg_pkg::*;
;
	logic        I_CLK       = 1'b0;
	logic        I_RST       = 1'b1;
	logic        I_WR        = 1'b0;
	logic [7:0]  I_ADDR      = 8'h00;
	logic [27:0] I_WDATA     = 28'h0000000;
	logic        I_LOAD      = 1'b0;
	logic [27:0] I_LOAD_DATA = 28'h0000000;
	logic        I_REF_SEL   = 1'b0;
	logic [27:0] O_RDATA;
	rscfg_ctl_t  O_CTL;
	int          fails           = 0;
	int          samples_checked = 0;

	// 200 MHz clock
	always #2.5 I_CLK = ~I_CLK;

	rscfg_reg i_rscfg_reg
	(
		.I_CLK       (I_CLK),
		.I_RST       (I_RST),
		.I_WR        (I_WR),
		.I_ADDR      (I_ADDR),
		.I_WDATA     (I_WDATA),
		.O_RDATA     (O_RDATA),
		.I_LOAD      (I_LOAD),
		.I_LOAD_DATA (I_LOAD_DATA),
		.I_REF_SEL   (I_REF_SEL),
		.O_CTL       (O_CTL)
	);

	// ****************************************************
	// Shared helpers
	// ****************************************************
	task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Write, then wait the extra edge that the decoded controls need
	task automatic wr(input logic [7:0] a, input logic [27:0] d);
		@(negedge I_CLK);
		I_WR = 1'b1;
		I_ADDR = a;
		I_WDATA = d;
		@(negedge I_CLK);
		I_WR = 1'b0;
		I_ADDR = 8'h00;
		@(negedge I_CLK);
	endtask

	// Buffers only judged in register mode, pin mode leaves them open
	task automatic wsel(input logic [27:0] d, input rscfg_src_t s, input logic b, input logic [1:0] pq);
		wr(8'h00, d);
		chk("source", 28'(s), 28'(O_CTL.source));
		if (b)
			chk("buffers on", 28'(pq), 28'({O_CTL.primary_buffer_on, O_CTL.secondary_buffer_on}));
	endtask

	// Checks read back with bit 8 cleared, plus buffer type, pulse width and pump fields
	task automatic wfld(input logic [27:0] d, input logic [1:0] bt, input logic [1:0] w, input logic [3:0] pm);
		wr(8'h00, d);
		chk("read back", d & ~28'h0000100, O_RDATA);
		chk("buf type", 28'(bt), 28'(O_CTL.buf_type));
		chk("pfd width", 28'(w), 28'(O_CTL.pfd_width));
		chk("pump", 28'(pm), 28'({O_CTL.pump_amp_off, O_CTL.pump_snk_on,
			O_CTL.pump_src_on, O_CTL.pump_negative}));
	endtask

	// ****************************************************
	// Scenarios
	// ****************************************************
	// Reset held five cycles, then pin mode picks the low pin
	task automatic test_reset();
		repeat (5) @(negedge I_CLK);
		I_RST = 1'b0;
		repeat (2) @(negedge I_CLK);
		chk("reset read", REG_RESET, O_RDATA);
		chk("reset source", 28'(RSCFG_SRC_SEC), 28'(O_CTL.source));
		$display("test reset done");
	endtask

	// Register mode with the pin held high, so it must be ignored
	task automatic test_reg_select();
		I_REF_SEL = 1'b1;
		repeat (4) @(negedge I_CLK);
		wsel(28'h0000020, RSCFG_SRC_NONE, 1'b1, 2'h0);
		wsel(28'h0000024, RSCFG_SRC_PRI, 1'b1, 2'h2);
		wsel(28'h0000028, RSCFG_SRC_SEC, 1'b1, 2'h1);
		wsel(28'h000002c, RSCFG_SRC_AUTO, 1'b1, 2'h3);
		$display("test register select done");
	endtask

	// Pin mode follows the synchronised pin both ways
	task automatic test_pin_select();
		wsel(28'h000000c, RSCFG_SRC_PRI, 1'b0, 2'h0);
		I_REF_SEL = 1'b0;
		repeat (4) @(negedge I_CLK);
		chk("pin source", 28'(RSCFG_SRC_SEC), 28'(O_CTL.source));
		$display("test pin select done");
	endtask

	// Aux bit overrides, clearing it restores the register choice
	task automatic test_aux_select();
		wsel(28'h0000034, RSCFG_SRC_AUX, 1'b1, 2'h0);
		wsel(28'h0000024, RSCFG_SRC_PRI, 1'b1, 2'h2);
		$display("test aux select done");
	endtask

	// Every field, reserved bit kept zero by the stimulus
	task automatic test_fields();
		wfld(28'habc1e41, 2'h2, 2'h1, 4'hf);
		wfld(28'h0000083, 2'h3, 2'h2, 4'h0);
		wfld(28'h0000000, 2'h0, 2'h0, 4'h0);
		wr(8'h01, 28'hfffffff);
		chk("unmapped write", 28'h0000000, O_RDATA);
		I_ADDR = 8'h01;
		#1;
		chk("unmapped read", 28'h0000000, O_RDATA);
		$display("test fields done");
	endtask

	// Load and write in one cycle, the stored word must win
	task automatic test_load();
		@(negedge I_CLK);
		I_ADDR = 8'h00;
		I_LOAD = 1'b1;
		I_LOAD_DATA = 28'h0000028;
		I_WR = 1'b1;
		I_WDATA = 28'h0000024;
		@(negedge I_CLK);
		I_LOAD = 1'b0;
		I_WR = 1'b0;
		@(negedge I_CLK);
		chk("load read", 28'h0000028, O_RDATA);
		chk("load source", 28'(RSCFG_SRC_SEC), 28'(O_CTL.source));
		$display("test load done");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog, the whole run needs well under 100 cycles
	initial
	begin
		#2000;
		fails++;
		end_sim();
	end

	// Main sequence
	initial
	begin
		test_reset();
		test_reg_select();
		test_pin_select();
		test_aux_select();
		test_fields();
		test_load();
		end_sim();
	end
endmodule
